// File: design/asw_defs.svh
`ifndef ASW_DEFS_SVH
`define ASW_DEFS_SVH

`define ASW_OP_WRITE_SECT      8'h30
`define ASW_OP_WRITE_SECT_RTY  8'h31
`define ASW_OP_WRITE_NOERASE   8'h38
`define ASW_OP_WRITE_VERIFY    8'h3C
`define ASW_OP_WRITE_MULT      8'hC5
`define ASW_OP_WRITE_MULT_NOER 8'hCD

`define ASW_WORDS_PER_SECTOR   9'h100
`define ASW_MULT_BLOCK_SIZE    8'h01
`define ASW_LBA_BIT            6

`define ASW_ERR_ABORT          8'h04
`define ASW_ERR_WRITE_FAULT    8'h40

`endif

// File: design/asw_pkg.sv
package asw_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_XFER,
    ST_PROGRAM,
    ST_WAIT,
    ST_DONE
  } asw_state_e;

  typedef enum logic [1:0] {
    WM_NORMAL,
    WM_NO_ERASE,
    WM_VERIFY,
    WM_FORCE_NO_ERASE
  } asw_wmode_e;
endpackage : asw_pkg

// File: design/asw_fifo.sv
`timescale 1ns/10ps
module asw_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;

  assign inReady  = (count_q != (AW+1)'(DEPTH)) && !flush;
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];

  always_ff @(posedge clk) begin
    if (doWrite) mem_q[wrPtr_q] <= inData;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWrite) wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
      if (doRead) rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
      count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule : asw_fifo

// File: design/asw_write_cmd.sv
`timescale 1ns/10ps
`include "asw_defs.svh"
module asw_write_cmd #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  cmdCode,
  input  wire logic        cmdStrobe,
  input  wire logic [7:0]  sectorCount,
  input  wire logic [7:0]  sectorNumber,
  input  wire logic [7:0]  cylinderLow,
  input  wire logic [7:0]  cylinderHigh,
  input  wire logic [7:0]  driveHead,
  input  wire logic [7:0]  multBlockSize,
  input  wire logic        multEnable,
  input  wire logic [15:0] hostData,
  input  wire logic        hostDataWrite,
  output logic             busy,
  output logic             dataRequest,
  output logic             errorFlag,
  output logic [7:0]       errorCode,
  output logic             intReq,
  output logic [7:0]       curSectorNumber,
  output logic [7:0]       curCylinderLow,
  output logic [7:0]       curCylinderHigh,
  output logic [3:0]       curHead,
  output logic [8:0]       sectorsLeft,
  output logic [27:0]      flashAddr,
  output logic             flashEraseFirst,
  output logic             flashVerify,
  output logic             flashStart,
  input  wire logic        flashDone,
  input  wire logic        flashFail,
  input  wire logic        flashSectorErased,
  output logic [15:0]      flashData,
  output logic             flashDataValid,
  input  wire logic        flashDataReady
);
  import asw_pkg::*;

  asw_state_e  state_q;
  asw_wmode_e  mode_q;
  logic        lba_q;
  logic [27:0] addr_q;
  logic [8:0]  left_q;
  logic [8:0]  words_q;
  logic        intReq_q;
  logic        err_q;
  logic [7:0]  errCode_q;
  logic        fifoReady;
  logic        fifoOutValid;
  logic [15:0] fifoOutData;

  function automatic logic [27:0] next_addr(input logic [27:0] a, input logic lba);
    logic [27:0] r;
    r = a + 28'h0000001;
    if (!lba) begin
      // chs: sector wraps within the track, head steps; geometry left to the flash side
      if (a[7:0] == 8'hFF) begin
        r[27:24] = a[27:24] + 4'h1;
        r[23:8]  = a[23:8] + ((a[27:24] == 4'hF) ? 16'h0001 : 16'h0000);
        r[7:0]   = 8'h01;
      end else begin
        r = {a[27:8], a[7:0] + 8'h01};
      end
    end
    return r;
  endfunction : next_addr

  wire isSect     = (cmdCode == `ASW_OP_WRITE_SECT) || (cmdCode == `ASW_OP_WRITE_SECT_RTY);
  wire isNoErase  = (cmdCode == `ASW_OP_WRITE_NOERASE);
  wire isVerify   = (cmdCode == `ASW_OP_WRITE_VERIFY);
  wire isMult     = (cmdCode == `ASW_OP_WRITE_MULT);
  wire isMultNoEr = (cmdCode == `ASW_OP_WRITE_MULT_NOER);
  wire isWriteCmd = isSect || isNoErase || isVerify || isMult || isMultNoEr;
  wire multBad    = (isMult || isMultNoEr)
                    && (!multEnable || multBlockSize != `ASW_MULT_BLOCK_SIZE);
  wire accept     = cmdStrobe && isWriteCmd && (state_q == ST_IDLE);
  wire [8:0] cnt  = (sectorCount == 8'h00) ? 9'h100 : {1'b0, sectorCount};
  // feature register never consulted
  wire [27:0] startAddr = {driveHead[3:0], cylinderHigh, cylinderLow,
                           sectorNumber};
  // host writes only land while request is up; busy guards the buffer
  wire wordIn     = hostDataWrite && dataRequest;

  asw_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .flush    (state_q == ST_IDLE),
    .inData   (hostData),
    .inValid  (wordIn),
    .inReady  (fifoReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (flashDataReady)
  );

  // request drops while fifo is full so the host stalls
  assign dataRequest     = (state_q == ST_XFER) && fifoReady && (words_q != 9'h000);
  assign busy            = (state_q == ST_SETUP) || (state_q == ST_PROGRAM) || (state_q == ST_WAIT)
                           || (state_q == ST_XFER && !dataRequest);
  assign flashData       = fifoOutData;
  assign flashDataValid  = fifoOutValid;
  assign flashAddr       = addr_q;
  assign flashStart      = (state_q == ST_SETUP);
  // 38h with a dirty sector falls back to erase-then-write
  assign flashEraseFirst = (mode_q == WM_NORMAL) || (mode_q == WM_VERIFY)
                           || ((mode_q == WM_NO_ERASE) && !flashSectorErased);
  assign flashVerify     = (mode_q == WM_VERIFY);
  assign intReq          = intReq_q;
  assign errorFlag       = err_q;
  assign errorCode       = errCode_q;
  assign curSectorNumber = addr_q[7:0];
  assign curCylinderLow  = addr_q[15:8];
  assign curCylinderHigh = addr_q[23:16];
  assign curHead         = addr_q[27:24];
  assign sectorsLeft     = left_q;

  // set wins over clear; the states keep the two apart anyway
  wire setInt     = (state_q == ST_WAIT) || (state_q == ST_DONE);
  wire firstWord  = (state_q == ST_XFER) && wordIn && (words_q == `ASW_WORDS_PER_SECTOR);
  wire clrInt     = ((state_q == ST_IDLE) && cmdStrobe) || firstWord;
  wire abortCmd   = accept && multBad;
  wire progFail   = (state_q == ST_PROGRAM) && flashDone && flashFail;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) intReq_q <= 1'b0;
    else if (setInt) intReq_q <= 1'b1;
    else if (clrInt) intReq_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_q     <= 1'b0;
      errCode_q <= 8'h00;
    end else if (abortCmd) begin
      err_q     <= 1'b1;
      errCode_q <= `ASW_ERR_ABORT;
    end else if (progFail) begin
      err_q     <= 1'b1;
      errCode_q <= `ASW_ERR_WRITE_FAULT;
    end else if (accept) begin
      err_q     <= 1'b0;
      errCode_q <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      mode_q  <= WM_NORMAL;
      lba_q   <= 1'b0;
      addr_q  <= '0;
      left_q  <= '0;
      words_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (abortCmd) begin
            state_q <= ST_DONE;
          end else if (accept) begin
            // no-erase variants skip the implicit erase; only 38h may fall back
            mode_q  <= isMultNoEr ? WM_FORCE_NO_ERASE :
                       isNoErase  ? WM_NO_ERASE :
                       isVerify   ? WM_VERIFY : WM_NORMAL;
            lba_q   <= driveHead[`ASW_LBA_BIT];
            addr_q  <= startAddr;
            left_q  <= cnt;
            words_q <= `ASW_WORDS_PER_SECTOR;
            state_q <= ST_SETUP; // busy first
          end
        end
        ST_SETUP: begin
          state_q <= ST_XFER; // request rises, busy drops, no interrupt
        end
        ST_XFER: begin
          if (wordIn && fifoReady) begin
            words_q <= words_q - 9'h001;
            if (words_q == 9'h001) state_q <= ST_PROGRAM; // busy up, request down
          end
        end
        ST_PROGRAM: begin
          if (progFail) begin
            state_q <= ST_DONE; // failing address stays put
          end else if (flashDone && left_q == 9'h001) begin
            left_q  <= 9'h000;
            state_q <= ST_DONE; // busy held until programmed
          end else if (flashDone) begin
            left_q  <= left_q - 9'h001;
            addr_q  <= next_addr(addr_q, lba_q);
            words_q <= `ASW_WORDS_PER_SECTOR;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state_q <= ST_XFER; // next sector: request plus interrupt
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule : asw_write_cmd

// File: test/asw_write_cmd_chk.sv
`timescale 1ns/10ps
module asw_write_cmd_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        cmdStrobe,
  input wire logic        multEnable,
  input wire logic        hostDataWrite,
  input wire logic        busy,
  input wire logic        dataRequest,
  input wire logic        errorFlag,
  input wire logic        intReq,
  input wire logic        flashEraseFirst,
  input wire logic        flashVerify,
  input wire logic        flashStart,
  input wire logic        flashDone,
  input wire logic        flashFail,
  input wire logic        flashSectorErased,
  input wire logic [7:0]  cmdCode,
  input wire logic [7:0]  sectorCount,
  input wire logic [7:0]  sectorNumber,
  input wire logic [7:0]  cylinderLow,
  input wire logic [7:0]  cylinderHigh,
  input wire logic [7:0]  driveHead,
  input wire logic [7:0]  multBlockSize,
  input wire logic [7:0]  errorCode,
  input wire logic [7:0]  curSectorNumber,
  input wire logic [8:0]  sectorsLeft,
  input wire logic [27:0] flashAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire idle = !busy && !dataRequest;
  wire isMult = cmdCode == 8'hC5 || cmdCode == 8'hCD;
  wire multOk = multEnable && multBlockSize == 8'h01;
  wire good = cmdStrobe && idle && (cmdCode == 8'h30 || cmdCode == 8'h31 ||
              cmdCode == 8'h38 || cmdCode == 8'h3C || (isMult && multOk));
  sequence sAcc; good; endsequence
  sequence sHand; busy && !intReq ##1 dataRequest && !busy && !intReq; endsequence
  AST_ACCEPT: assert property (sAcc |-> ##1 sHand)
    else $error("accept handshake wrong");
  AST_ABORT: assert property (cmdStrobe && idle && isMult && !multOk |->
    ##2 intReq && errorFlag && errorCode == 8'h04) else $error("abort wrong");
  AST_NOERASE: assert property (sAcc and cmdCode == 8'hCD |=>
    flashStart && !flashEraseFirst) else $error("erase on CD");
  AST_FALLBACK: assert property (sAcc and cmdCode == 8'h38 |=>
    flashEraseFirst == !flashSectorErased) else $error("38 erase choice");
  AST_VERIFY: assert property (sAcc and cmdCode == 8'h3C |=> flashVerify)
    else $error("no verify");
  AST_COUNT: assert property (sAcc |=> sectorsLeft ==
    ($past(sectorCount) == 8'h00 ? 9'h100 : {1'b0, $past(sectorCount)}))
    else $error("sector count");
  AST_LBA: assert property (sAcc and driveHead[6] |=>
    curSectorNumber == $past(sectorNumber)
    && flashAddr == $past({driveHead[3:0], cylinderHigh, cylinderLow, sectorNumber}))
    else $error("lba address");
  AST_DREQ: assert property (dataRequest |-> !busy) else $error("request while busy");
  AST_DONE: assert property (flashDone && !flashFail |-> ##[1:2] intReq && !busy)
    else $error("no completion interrupt");
  AST_FAIL: assert property (flashDone && flashFail |-> ##[1:2]
    errorFlag && errorCode == 8'h40 && intReq && !dataRequest) else $error("fail report");
  // every sector is 256 words, so a free-running count stays aligned
  logic [7:0] wordCnt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) wordCnt_q <= 8'h00;
    else if (dataRequest && hostDataWrite) wordCnt_q <= wordCnt_q + 8'h01;
  end
  wire lastWord = dataRequest && hostDataWrite && wordCnt_q == 8'hFF;
  AST_SECTOR_END: assert property (lastWord |=>
    busy && !dataRequest && !intReq) else $error("sector end handshake");
endmodule : asw_write_cmd_chk
bind asw_write_cmd asw_write_cmd_chk asw_write_cmd_chk_i (.*);

// File: test/asw_flash_model.sv
`timescale 1ns/10ps
module asw_flash_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic flashDataValid,
  input  wire logic stall,
  input  wire logic failNext,
  output logic      flashDataReady,
  output logic      flashDone,
  output logic      flashFail
);
  int words, waitCnt;
  assign flashDataReady = !stall;
  // fail line carries junk outside the done pulse
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      words <= 0; waitCnt <= 0; flashDone <= 0; flashFail <= 0;
    end else begin
      flashDone <= waitCnt == 1;
      flashFail <= waitCnt == 1 ? failNext : !failNext;
      if (waitCnt != 0) waitCnt <= waitCnt - 1;
      if (flashDataValid && !stall) begin
        words <= words == 255 ? 0 : words + 1;
        if (words == 255) waitCnt <= 7;
      end
    end
  end
endmodule : asw_flash_model

// File: test/asw_write_cmd_tb.sv
`timescale 1ns/10ps
module asw_write_cmd_tb;
  logic clk = 0, reset_n = 0, cmdStrobe = 0, multEnable = 1, hostDataWrite = 0;
  logic flashSectorErased = 0, stall = 0, failNext = 0;
  logic [7:0] cmdCode = 0, sectorCount = 0, sectorNumber = 0, cylinderLow = 0;
  logic [7:0] cylinderHigh = 0, driveHead = 0, multBlockSize = 1;
  logic [15:0] hostData = 0;
  wire busy, dataRequest, errorFlag, intReq, flashEraseFirst, flashVerify, flashStart;
  wire flashDone, flashFail, flashDataValid, flashDataReady;
  wire [7:0] errorCode, curSectorNumber, curCylinderLow, curCylinderHigh;
  wire [3:0] curHead;
  wire [8:0] sectorsLeft;
  wire [27:0] flashAddr;
  wire [15:0] flashData;
  int errors = 0, checks_done = 0, cyc = 0, i;
  logic [31:0] rs = 32'h1AF0;
  logic [15:0] q[$];
  logic [7:0] ops[6] = '{8'h30, 8'h31, 8'h38, 8'h3C, 8'hC5, 8'hCD};
  asw_write_cmd asw_write_cmd_i (.*);
  asw_flash_model asw_flash_model_i (.*);
  always #50 clk = ~clk;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
    return rs;
  endfunction : rnd
  function automatic logic [8:0] cnt(input logic [7:0] c);
    return c == 8'h00 ? 9'h100 : {1'b0, c};
  endfunction : cnt
  task chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin errors++; $display("MISMATCH %0t %s", $time, m); end
  endtask : chk
  task close_out();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task tick(); @(posedge clk); #5; endtask : tick
  task wt(); int n;
    for (n = 0; n < 3000 && !(dataRequest || (!busy && intReq)); n++) tick();
  endtask : wt
  task sector(); int k, n;
    for (k = 0; k < 256; k++) begin
      for (n = 0; n < 500 && !dataRequest; n++) begin hostDataWrite = 0; tick(); end
      hostData = 16'(rnd()); q.push_back(hostData); hostDataWrite = 1; tick();
    end
    hostDataWrite = 0;
  endtask : sector
  task run(input logic [7:0] op, input logic [7:0] sc, input logic fail); int s;
    sectorNumber = 8'(rnd()); cylinderLow = rs[15:8]; cylinderHigh = rs[23:16];
    driveHead = {1'b1, rs[0], 2'b10, rs[7:4]}; flashSectorErased = rs[9];
    sectorCount = sc; cmdCode = op; failNext = fail; cmdStrobe = 1; tick();
    cmdStrobe = 0; tick();
    chk(sectorsLeft === cnt(sc), "count");
    for (s = 0; s < cnt(sc); s++) begin
      wt(); chk(dataRequest === 1'b1 && intReq === (s != 0), "request");
      sector();
      if (fail) break;
    end
    wt(); chk(!busy && !dataRequest && intReq && errorFlag === fail, "end");
    if (fail) chk(curSectorNumber === sectorNumber && errorCode === 8'h40, "fail");
    if (fail) chk({curHead, curCylinderHigh, curCylinderLow}
                  === {driveHead[3:0], cylinderHigh, cylinderLow}, "fail address");
    repeat (3) tick();
  endtask : run
  always @(posedge clk) begin cyc++; #5 stall = cyc[6] && cyc[1:0] != 2'b00; end
  always @(negedge clk) if (reset_n && flashDataValid && flashDataReady) begin
    chk(q.size() > 0 && flashData === q[0], "data");
    if (q.size() > 0) void'(q.pop_front());
  end
  initial begin #3_000_000; errors++; close_out(); end
  initial begin
    repeat (16) @(posedge clk); #5 reset_n = 1;
    hostDataWrite = 1; tick(); hostDataWrite = 0; tick();
    for (i = 0; i < 2; i++) begin
      multEnable = i[0]; multBlockSize = 8'h01 + i[7:0]; cmdCode = i ? 8'hCD : 8'hC5;
      cmdStrobe = 1; tick(); cmdStrobe = 0; tick(); tick();
      chk(errorFlag === 1'b1 && errorCode === 8'h04 && !busy, "abort");
    end
    multEnable = 1; multBlockSize = 8'h01;
    foreach (ops[j]) run(ops[j], 8'(1 + rnd() % 2), 1'b0);
    run(8'h31, 8'h00, 1'b1);
    run(8'hC5, 8'h02, 1'b1);
    close_out();
  end
endmodule : asw_write_cmd_tb
